// ### logic/nid_pkg.sv
package nid_pkg;
   // ************************************************
   // Register map
   // ************************************************
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] OFS_NODE_IDENTITY = 12'h0e8;
   localparam logic [ADDR_W-1:0] OFS_PHY_ACCESS = 12'h0ec;
   localparam logic [ADDR_W-1:0] OFS_INT_STATUS = 12'h1f0;
   localparam logic [ADDR_W-1:0] OFS_INT_MASK = 12'h1f4;

   // ************************************************
   // Field layout
   // ************************************************
   localparam int NID_VALID_BIT = 31;
   localparam int NID_ROOT_BIT = 30;
   localparam int NID_POWER_BIT = 27;
   localparam int NID_SEGMENT_LSB = 6;
   localparam int NID_NODE_LSB = 0;
   localparam int PA_DONE_BIT = 31;
   localparam int PA_RET_INDEX_LSB = 24;
   localparam int PA_RET_VALUE_LSB = 16;
   localparam int PA_READ_BIT = 15;
   localparam int PA_WRITE_BIT = 14;
   localparam int PA_TARGET_LSB = 8;
   localparam int PA_VALUE_LSB = 0;
   localparam int INT_BUS_RESET = 0;
   localparam int INT_SELF_ID = 1;
   localparam int INT_READ_DONE = 2;
   localparam int INT_W = 3;

   // ************************************************
   // Reset values and timing
   // ************************************************
   localparam logic [9:0] SEGMENT_RESET = 10'h3ff;
   localparam logic [5:0] NODE_RESET = 6'h00;
   localparam logic [INT_W-1:0] INT_RESET = 3'h0;
   localparam logic [1:0] PHY_REPLY_CYCLES = 2'h2;

   typedef enum logic [0:0]
   {
      NID_IDLE = 1'b0,
      NID_WAIT = 1'b1
   } nid_link_state_t;
endpackage

// ### logic/nid_link_if.sv
`timescale 1ns/10ps
interface nid_link_if;
   logic req_valid;
   logic req_write;
   logic [3:0] req_index;
   logic [7:0] req_data;
   logic xfer_valid;
   logic [3:0] xfer_index;
   logic [7:0] xfer_data;
   logic bus_reset;
   logic self_id_done;
   logic [5:0] self_id_node;
   logic phy_is_root;
   logic phy_power_ok;

   modport link_end
   (
      output req_valid, req_write, req_index, req_data,
      input xfer_valid, xfer_index, xfer_data, bus_reset, self_id_done,
      input self_id_node, phy_is_root, phy_power_ok
   );
   modport phy_end
   (
      input req_valid, req_write, req_index, req_data,
      output xfer_valid, xfer_index, xfer_data, bus_reset, self_id_done,
      output self_id_node, phy_is_root, phy_power_ok
   );
endinterface

// ### logic/nid_phy_end.sv
`timescale 1ns/10ps
module nid_phy_end
   import nid_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   nid_link_if.phy_end link,
   input wire logic start_bus_reset,
   input wire logic finish_self_id,
   input wire logic [5:0] assigned_node,
   input wire logic root_status,
   input wire logic power_status,
   output logic reg_write_seen,
   output logic [3:0] reg_write_index,
   output logic [7:0] reg_write_value
);
   // ************************************************
   // PHY register file
   // ************************************************
   logic [7:0] phy_regs [16];
   logic [1:0] reply_count;
   logic reply_busy;
   logic [3:0] reply_index;

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         for (int i = 0; i < 16; i++)
         begin
            phy_regs[i] <= 8'h00;
         end
      end
      else if (link.req_valid && link.req_write)
      begin
         phy_regs[link.req_index] <= link.req_data;
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         reg_write_seen <= 1'b0;
         reg_write_index <= 4'h0;
         reg_write_value <= 8'h00;
      end
      else
      begin
         reg_write_seen <= link.req_valid && link.req_write;
         if (link.req_valid && link.req_write)
         begin
            reg_write_index <= link.req_index;
            reg_write_value <= link.req_data;
         end
      end
   end

   // ************************************************
   // Read reply
   // ************************************************
   // A fixed delay stands in for the serial register transfer
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         reply_busy <= 1'b0;
         reply_count <= 2'h0;
         reply_index <= 4'h0;
         link.xfer_valid <= 1'b0;
         link.xfer_index <= 4'h0;
         link.xfer_data <= 8'h00;
      end
      else
      begin
         link.xfer_valid <= 1'b0;
         if (link.req_valid && !link.req_write)
         begin
            reply_busy <= 1'b1;
            reply_count <= PHY_REPLY_CYCLES - 2'h1;
            reply_index <= link.req_index;
         end
         else if (reply_busy && reply_count != 2'h0)
         begin
            reply_count <= reply_count - 2'h1;
         end
         else if (reply_busy)
         begin
            reply_busy <= 1'b0;
            link.xfer_valid <= 1'b1;
            link.xfer_index <= reply_index;
            link.xfer_data <= phy_regs[reply_index];
         end
      end
   end

   // ************************************************
   // Bus status
   // ************************************************
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         link.bus_reset <= 1'b0;
         link.self_id_done <= 1'b0;
         link.self_id_node <= NODE_RESET;
         link.phy_is_root <= 1'b0;
         link.phy_power_ok <= 1'b0;
      end
      else
      begin
         link.bus_reset <= start_bus_reset;
         link.self_id_done <= finish_self_id;
         link.self_id_node <= assigned_node;
         link.phy_is_root <= root_status;
         link.phy_power_ok <= power_status;
      end
   end
endmodule

// ### logic/nid_link_end.sv
// Our own choice: the address-and-strobe port.
`timescale 1ns/10ps
module nid_link_end
   import nid_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   nid_link_if.link_end phy,
   input wire logic [ADDR_W-1:0] sw_addr,
   input wire logic [31:0] sw_wdata,
   input wire logic sw_write,
   input wire logic sw_read,
   output logic [31:0] sw_rdata,
   output logic irq
);
   // ************************************************
   // State
   // ************************************************
   logic node_number_valid;
   logic is_root;
   logic cable_power_ok;
   logic in_bus_reset;
   logic [9:0] bus_segment_id;
   logic [5:0] physical_node_index;
   logic phy_read_complete;
   logic [3:0] phy_returned_reg_index;
   logic [7:0] phy_returned_value;
   logic phy_read_request;
   logic phy_write_request;
   logic [3:0] phy_target_reg_index;
   logic [7:0] phy_write_value;
   logic [INT_W-1:0] int_status;
   logic [INT_W-1:0] int_mask;
   logic [INT_W-1:0] next_int_status;
   logic [INT_W-1:0] int_events;
   nid_link_state_t state;
   logic wr_node;
   logic wr_access;
   logic wr_status;
   logic wr_mask;
   logic launch;
   logic launch_read;
   logic [31:0] node_word;
   logic [31:0] access_word;

   // ************************************************
   // Write decode
   // ************************************************
   always_comb
   begin
      wr_node = 1'b0;
      wr_access = 1'b0;
      wr_status = 1'b0;
      wr_mask = 1'b0;
      if (!sw_write)
      begin
         wr_node = 1'b0;
      end
      else if (sw_addr == OFS_NODE_IDENTITY)
      begin
         wr_node = 1'b1;
      end
      else if (sw_addr == OFS_PHY_ACCESS)
      begin
         wr_access = 1'b1;
      end
      else if (sw_addr == OFS_INT_STATUS)
      begin
         wr_status = 1'b1;
      end
      else if (sw_addr == OFS_INT_MASK)
      begin
         wr_mask = 1'b1;
      end
   end

   // ************************************************
   // Node identity
   // ************************************************
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         in_bus_reset <= 1'b0;
      end
      else if (phy.self_id_done)
      begin
         in_bus_reset <= 1'b0;
      end
      else if (phy.bus_reset)
      begin
         in_bus_reset <= 1'b1;
      end
   end

   // New node wins over a bus reset in the same cycle
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         node_number_valid <= 1'b0;
      end
      else if (phy.self_id_done)
      begin
         node_number_valid <= 1'b1;
      end
      else if (phy.bus_reset)
      begin
         node_number_valid <= 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         is_root <= 1'b0;
      end
      else if (phy.bus_reset || in_bus_reset)
      begin
         is_root <= phy.phy_is_root;
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         cable_power_ok <= 1'b0;
      end
      else
      begin
         cable_power_ok <= phy.phy_power_ok;
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         bus_segment_id <= SEGMENT_RESET;
      end
      else if (wr_node)
      begin
         bus_segment_id <= sw_wdata[NID_SEGMENT_LSB +: 10];
      end
   end

   // Software writes never reach the node index
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         physical_node_index <= NODE_RESET;
      end
      else if (phy.self_id_done)
      begin
         physical_node_index <= phy.self_id_node;
      end
   end

   // ************************************************
   // PHY register access
   // ************************************************
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         phy_target_reg_index <= 4'h0;
         phy_write_value <= 8'h00;
      end
      else if (wr_access)
      begin
         phy_target_reg_index <= sw_wdata[PA_TARGET_LSB +: 4];
         phy_write_value <= sw_wdata[PA_VALUE_LSB +: 8];
      end
   end

   // Read takes priority should software ever set both bits
   assign launch = (state == NID_IDLE) && (phy_read_request || phy_write_request);
   assign launch_read = launch && phy_read_request;

   // Writing zero leaves a pending request alone
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         phy_read_request <= 1'b0;
         phy_write_request <= 1'b0;
      end
      else
      begin
         phy_read_request <= (phy_read_request && !launch_read)
            || (wr_access && sw_wdata[PA_READ_BIT]);
         phy_write_request <= (phy_write_request && !(launch && !launch_read))
            || (wr_access && sw_wdata[PA_WRITE_BIT]);
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         phy.req_valid <= 1'b0;
         phy.req_write <= 1'b0;
         phy.req_index <= 4'h0;
         phy.req_data <= 8'h00;
      end
      else
      begin
         phy.req_valid <= launch;
         if (launch)
         begin
            phy.req_write <= !phy_read_request;
            phy.req_index <= phy_target_reg_index;
            phy.req_data <= phy_read_request ? 8'h00 : phy_write_value;
         end
      end
   end

   // A bus reset abandons the read wait, though the PHY still sends its reply after the fixed delay
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         state <= NID_IDLE;
      end
      else
      begin
         case (state)
            NID_IDLE:
            begin
               if (launch_read)
               begin
                  state <= NID_WAIT;
               end
            end
            NID_WAIT:
            begin
               if (phy.xfer_valid || phy.bus_reset)
               begin
                  state <= NID_IDLE;
               end
            end
            default:
            begin
               state <= NID_IDLE;
            end
         endcase
      end
   end

   // Arrival wins over a clearing write in the same cycle
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         phy_read_complete <= 1'b0;
      end
      else if (phy.xfer_valid)
      begin
         phy_read_complete <= 1'b1;
      end
      else if (wr_access && (sw_wdata[PA_READ_BIT] || sw_wdata[PA_WRITE_BIT]))
      begin
         phy_read_complete <= 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         phy_returned_reg_index <= 4'h0;
         phy_returned_value <= 8'h00;
      end
      else if (phy.xfer_valid)
      begin
         phy_returned_reg_index <= phy.xfer_index;
         phy_returned_value <= phy.xfer_data;
      end
   end

   // ************************************************
   // Interrupts
   // ************************************************
   assign int_events = {phy.xfer_valid, phy.self_id_done, phy.bus_reset};

   always_comb
   begin
      next_int_status = int_status;
      if (wr_status)
      begin
         next_int_status = int_status & ~sw_wdata[INT_W-1:0];
      end
      next_int_status = next_int_status | int_events;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         int_status <= INT_RESET;
         int_mask <= INT_RESET;
         irq <= 1'b0;
      end
      else
      begin
         int_status <= next_int_status;
         if (wr_mask)
         begin
            int_mask <= sw_wdata[INT_W-1:0];
         end
         irq <= |(next_int_status & (wr_mask ? sw_wdata[INT_W-1:0] : int_mask));
      end
   end

   // ************************************************
   // Read back
   // ************************************************
   always_comb
   begin
      node_word = 32'h0000_0000;
      node_word[NID_VALID_BIT] = node_number_valid;
      node_word[NID_ROOT_BIT] = is_root;
      node_word[NID_POWER_BIT] = cable_power_ok;
      node_word[15:0] = {bus_segment_id, physical_node_index};
      access_word = 32'h0000_0000;
      access_word[PA_DONE_BIT] = phy_read_complete;
      access_word[PA_RET_INDEX_LSB +: 4] = phy_returned_reg_index;
      access_word[PA_RET_VALUE_LSB +: 8] = phy_returned_value;
      access_word[PA_READ_BIT] = phy_read_request;
      access_word[PA_WRITE_BIT] = phy_write_request;
      access_word[PA_TARGET_LSB +: 4] = phy_target_reg_index;
      access_word[PA_VALUE_LSB +: 8] = phy_write_value;
   end

   // Data stand for exactly the cycle after the strobe
   always_ff @(posedge clk)
   begin
      if (reset || !sw_read)
      begin
         sw_rdata <= 32'h0000_0000;
      end
      else if (sw_addr == OFS_NODE_IDENTITY)
      begin
         sw_rdata <= node_word;
      end
      else if (sw_addr == OFS_PHY_ACCESS)
      begin
         sw_rdata <= access_word;
      end
      else if (sw_addr == OFS_INT_STATUS)
      begin
         sw_rdata <= {29'h0, int_status};
      end
      else if (sw_addr == OFS_INT_MASK)
      begin
         sw_rdata <= {29'h0, int_mask};
      end
      else
      begin
         sw_rdata <= 32'h0000_0000;
      end
   end
endmodule

// ### tb/nid_props.sv
`timescale 1ns/10ps
module nid_props
(
   input wire logic clk,
   input wire logic reset,
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [3:0] req_index,
   input wire logic [7:0] req_data,
   input wire logic xfer_valid,
   input wire logic [3:0] xfer_index,
   input wire logic [7:0] xfer_data,
   input wire logic bus_reset
);
   // ************************************************
   // Mirror of the far register file
   // ************************************************
   logic [7:0] mirror [16];
   logic [7:0] expect_data;

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         for (int i = 0; i < 16; i++)
         begin
            mirror[i] <= 8'h00;
         end
      end
      else if (req_valid && req_write)
      begin
         mirror[req_index] <= req_data;
      end
   end

   // Captured at the request, since a later write may overlap a read wait abandoned by a bus reset
   always_ff @(posedge clk)
   begin
      if (req_valid && !req_write)
      begin
         expect_data <= mirror[req_index];
      end
   end

   // ************************************************
   // Request and transfer properties
   // ************************************************
   default clocking @(posedge clk);
   endclocking
   default disable iff (reset);

   sequence read_req;
      req_valid && !req_write;
   endsequence

   sequence write_req;
      req_valid && req_write;
   endsequence

   read_reply_a: assert property (read_req |-> ##3 xfer_valid)
      else $error("read request got no transfer");
   reply_index_a: assert property (read_req |-> ##3 (xfer_index == $past(req_index, 3)))
      else $error("returned index differs from requested");
   reply_data_a: assert property (xfer_valid |-> xfer_data == expect_data)
      else $error("returned value differs from last write");
   write_silent_a: assert property (write_req |-> ##3 !xfer_valid)
      else $error("write request got a transfer");
   read_zero_a: assert property (read_req |-> req_data == 8'h00)
      else $error("read request carries data");
   req_pulse_a: assert property (req_valid |=> !req_valid)
      else $error("request longer than one cycle");
   read_hold_a: assert property ((read_req and !bus_reset) ##1 (!bus_reset)[*2] |-> ##1 !req_valid)
      else $error("request issued during read wait");
   xfer_pulse_a: assert property (xfer_valid |=> !xfer_valid)
      else $error("transfer longer than one cycle");
endmodule

// ### tb/node_id_and_phy_reg_access_tb.sv
`timescale 1ns/10ps
module node_id_and_phy_reg_access_tb;
   import nid_pkg::*;
   // ************************************************
   // Stimulus and instances
   // ************************************************
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [ADDR_W-1:0] sw_addr = '0;
   logic [31:0] sw_wdata = '0;
   logic sw_write = 1'b0;
   logic sw_read = 1'b0;
   logic [31:0] sw_rdata;
   logic irq;
   logic start_bus_reset = 1'b0;
   logic finish_self_id = 1'b0;
   logic [5:0] assigned_node = 6'h00;
   logic root_status = 1'b0;
   logic power_status = 1'b0;
   logic reg_write_seen;
   logic [3:0] reg_write_index;
   logic [7:0] reg_write_value;
   int n_fail = 0;
   int check_count = 0;
   int cycles = 0;

   always #5 clk = ~clk;

   nid_link_if link_bus();

   nid_link_end nid_link_end_inst (.clk(clk), .reset(reset), .phy(link_bus),
      .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_write(sw_write), .sw_read(sw_read),
      .sw_rdata(sw_rdata), .irq(irq));
   nid_phy_end nid_phy_end_inst (.clk(clk), .reset(reset), .link(link_bus),
      .start_bus_reset(start_bus_reset), .finish_self_id(finish_self_id),
      .assigned_node(assigned_node), .root_status(root_status), .power_status(power_status),
      .reg_write_seen(reg_write_seen), .reg_write_index(reg_write_index),
      .reg_write_value(reg_write_value));
   nid_props nid_props_inst (.clk(clk), .reset(reset), .req_valid(link_bus.req_valid),
      .req_write(link_bus.req_write), .req_index(link_bus.req_index),
      .req_data(link_bus.req_data), .xfer_valid(link_bus.xfer_valid),
      .xfer_index(link_bus.xfer_index), .xfer_data(link_bus.xfer_data),
      .bus_reset(link_bus.bus_reset));

   // ************************************************
   // Tasks
   // ************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic sw_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge clk);
      sw_addr <= a;
      sw_wdata <= d;
      sw_write <= 1'b1;
      @(posedge clk);
      sw_write <= 1'b0;
   endtask

   task automatic sw_rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
      @(posedge clk);
      sw_addr <= a;
      sw_read <= 1'b1;
      @(posedge clk);
      sw_read <= 1'b0;
      #1 check(sw_rdata, exp);
   endtask

   // Forwarding takes one cycle, the flags one more, so three cycles settle it
   task automatic bus_evt(input logic self_id);
      @(posedge clk);
      if (self_id)
         finish_self_id <= 1'b1;
      else
         start_bus_reset <= 1'b1;
      @(posedge clk);
      finish_self_id <= 1'b0;
      start_bus_reset <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   task automatic wrap_up();
      if (n_fail == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cycles++;
      if (cycles > 3000)
      begin
         n_fail++;
         wrap_up();
      end
   end

   // ************************************************
   // Main sequence
   // ************************************************
   initial
   begin
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      sw_rd(OFS_NODE_IDENTITY, 32'h0000ffc0);
      sw_rd(OFS_PHY_ACCESS, 32'h00000000);
      sw_rd(12'h100, 32'h00000000);
      sw_wr(OFS_NODE_IDENTITY, 32'hffff5a7f);
      sw_rd(OFS_NODE_IDENTITY, 32'h00005a40);
      // Identity after a bus reset and self-identification
      root_status <= 1'b1;
      power_status <= 1'b1;
      assigned_node <= 6'h2a;
      bus_evt(1'b0);
      bus_evt(1'b1);
      sw_rd(OFS_NODE_IDENTITY, 32'hc8005a6a);
      sw_rd(OFS_INT_STATUS, 32'h00000003);
      check({31'h0, irq}, 32'h0);
      sw_wr(OFS_INT_STATUS, 32'h00000003);
      sw_rd(OFS_INT_STATUS, 32'h00000000);
      // Far register write with reserved bits set
      sw_wr(OFS_PHY_ACCESS, 32'h70007a5c);
      for (int k = 0; k < 10 && reg_write_seen !== 1'b1; k++)
         @(posedge clk) #1;
      check({31'h0, reg_write_seen}, 32'h1);
      check({28'h0, reg_write_index}, 32'h0000000a);
      check({24'h0, reg_write_value}, 32'h0000005c);
      sw_rd(OFS_PHY_ACCESS, 32'h00000a5c);
      // Far register read returns the written byte and raises the interrupt
      sw_wr(OFS_INT_MASK, 32'h00000004);
      sw_wr(OFS_PHY_ACCESS, 32'h00008aff);
      repeat (6) @(posedge clk);
      sw_rd(OFS_PHY_ACCESS, 32'h8a5c0aff);
      check({31'h0, irq}, 32'h1);
      sw_wr(OFS_INT_STATUS, 32'h00000004);
      repeat (2) @(posedge clk);
      check({31'h0, irq}, 32'h0);
      // A new request clears the complete flag
      sw_wr(OFS_PHY_ACCESS, 32'h00004300);
      repeat (4) @(posedge clk);
      sw_rd(OFS_PHY_ACCESS, 32'h0a5c0300);
      // Second bus reset as non-root without power
      root_status <= 1'b0;
      power_status <= 1'b0;
      assigned_node <= 6'h15;
      bus_evt(1'b0);
      sw_rd(OFS_NODE_IDENTITY, 32'h00005a6a);
      bus_evt(1'b1);
      sw_rd(OFS_NODE_IDENTITY, 32'h80005a55);
      wrap_up();
   end
endmodule
